// >>> shared/slt_pkg.sv
// constants for the switch lookup table control and status registers
//
// Behaviour
// RL1: After a fabric reset the init-done bit reads 0, the table is initialized for about 20 us, and then the bit sets itself to 1.
// RL2: While table initialization is running every packet arriving on any port is dropped.
// RL3: Software should poll init-done and wait for 1 before writing table entries or lookup configuration.
// RL4: Status bit 0 is high while a table command executes, clears itself at command completion, and resets to 0.
// RL5: The aging time field in bits 27:16 gives a minimum aging interval of value plus one seconds.
// RL6: The aging time field resets to 129h, a minimum interval of 298 seconds.
// RL7: The broadcast address may be used as a table entry only while configuration bit 2 is set; it resets to 0.
// RL8: Entry aging runs only while configuration bit 1 is set; it resets to 1.
// RL9: With configuration bit 0 set the aging timer counts milliseconds instead of seconds; it resets to 0.
// RL10: With the port-2 override enabled, port-2 packets go to the port chosen by bits 10:9 (00 port 0, 01 port 1, 10 reserved); the field resets to 00b.
// RL11: With override enable bit 8 set the destination lookup result of port-2 packets is replaced, all other entry data still applies.
// RL12: Reserved bits of the three registers read as zero and ignore writes.
package slt_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [13:0] IDX_CMD_STS = 14'h1808;
    localparam logic [13:0] IDX_CFG = 14'h1809;
    localparam logic [13:0] IDX_OVERRIDE = 14'h180A;
    localparam logic [13:0] IDX_IRQ_STATUS = 14'h1810;
    localparam logic [13:0] IDX_IRQ_CLEAR = 14'h1811;
    localparam logic [13:0] IDX_IRQ_ENABLE = 14'h1812;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int STS_PENDING_BIT = 0;
    localparam int STS_INIT_DONE_BIT = 1;
    localparam int CFG_TEST_BIT = 0;
    localparam int CFG_AGE_EN_BIT = 1;
    localparam int CFG_BCAST_BIT = 2;
    localparam int CFG_AGE_LSB = 16;
    localparam int CFG_AGE_MSB = 27;
    localparam int OVR_EN_BIT = 8;
    localparam int OVR_SEL_LSB = 9;
    localparam int OVR_SEL_MSB = 10;
    localparam logic [11:0] AGE_TIME_RST = 12'h129;
    localparam logic AGE_EN_RST = 1'b1;
    localparam logic BCAST_RST = 1'b0;
    localparam logic TEST_RST = 1'b0;
    localparam logic OVR_EN_RST = 1'b0;
    localparam logic [1:0] OVR_SEL_RST = 2'h0;

    // override selector codes and forwarding port codes
    localparam logic [1:0] OVR_SEL_PORT0 = 2'h0;
    localparam logic [1:0] OVR_SEL_PORT1 = 2'h1;
    localparam logic [1:0] INGRESS_PORT2 = 2'h2;
    localparam logic [2:0] DEST_PORT0 = 3'h0;
    localparam logic [2:0] DEST_PORT1 = 3'h1;

    // interrupt event bits
    localparam int IRQ_W = 3;
    localparam int EV_INIT_DONE = 0;
    localparam int EV_CMD_DONE = 1;
    localparam int EV_AGE_SWEEP = 2;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_FREQ_HZ = 20_000_000;
    localparam int INIT_TIME_US = 20;
    localparam int INIT_CYCLES = INIT_TIME_US * (CLK_FREQ_HZ / 1_000_000);
    localparam logic [8:0] INIT_CNT_LAST = 9'(INIT_CYCLES - 1);
    localparam int MS_TIME_US = 1000;
    localparam int MS_CYCLES_DFLT = MS_TIME_US * (CLK_FREQ_HZ / 1_000_000);
    localparam int MS_CNT_W = 15;
    localparam int MS_PER_S = 1000;
    localparam logic [9:0] MS_PER_S_LAST = 10'(MS_PER_S - 1);

endpackage

// >>> tb/slt_ctrl_test.sv
// self-checking bench for the lookup table control and status registers
module slt_ctrl_test;
    import slt_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int MSC = 4;
    localparam int LIMIT = 20000;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [15:0] avs_address = 16'h0000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic cmd_start = 1'b0;
    logic cmd_done = 1'b0;
    logic lookup_valid = 1'b0;
    logic [1:0] lookup_ingress = 2'h0;
    logic [2:0] lookup_dest = 3'h0;
    logic result_valid, drop_all, age_enable, age_sweep, allow_broadcast, irq;
    logic [2:0] result_dest;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int t0, t1, t2;
    logic [31:0] rd_q[$];
    logic [2:0] res_q[$];

    slt_ctrl #(.MS_CYCLES(MSC)) slt_ctrl_i (.core_clk(core_clk), .resetn(resetn),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .cmd_start(cmd_start), .cmd_done(cmd_done), .lookup_valid(lookup_valid),
        .lookup_ingress(lookup_ingress), .lookup_dest(lookup_dest),
        .result_valid(result_valid), .result_dest(result_dest), .drop_all(drop_all),
        .age_enable(age_enable), .age_sweep(age_sweep), .allow_broadcast(allow_broadcast),
        .irq(irq));

    initial begin
        forever #25 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // comparison, verdict and hang guard
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (err_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc > LIMIT) begin
            err_count++;
            tally_and_finish();
        end
    end

    // results are matched against the oldest note; an unexpected one is a mismatch
    always @(posedge core_clk) begin
        if (resetn === 1'b1 && avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            if (rd_q.size() == 0) check(avs_readdata, 32'hDEAD_BEEF);
            else check(avs_readdata, rd_q.pop_front());
        end
        if (resetn === 1'b1 && result_valid !== 1'b0) begin
            if (res_q.size() == 0) check({29'h0, result_dest}, 32'hDEAD_BEEF);
            else check({29'h0, result_dest}, {29'h0, res_q.pop_front()});
        end
    end

    // ------------------------------------------------------------
    // bus cycles and stimulus helpers
    // ------------------------------------------------------------
    task automatic bus_wait();
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) check(32'h0, 32'h1);
    endtask

    task automatic bus_write(input logic [13:0] idx, input logic [31:0] d);
        @(posedge core_clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= d;
        avs_write <= 1'b1;
        bus_wait();
        avs_write <= 1'b0;
        avs_writedata <= ~d;
    endtask

    task automatic bus_read(input logic [13:0] idx, input logic [31:0] exp);
        rd_q.push_back(exp);
        @(posedge core_clk);
        avs_address <= {idx, 2'b00};
        avs_read <= 1'b1;
        bus_wait();
        avs_read <= 1'b0;
    endtask

    task automatic lookup(input logic [1:0] ing, input logic [2:0] dst, input logic [2:0] exp);
        res_q.push_back(exp);
        @(posedge core_clk);
        lookup_valid <= 1'b1;
        lookup_ingress <= ing;
        lookup_dest <= dst;
        @(posedge core_clk);
        lookup_valid <= 1'b0;
    endtask

    task automatic pulse_cmd(input logic st);
        @(posedge core_clk);
        if (st) cmd_start <= 1'b1;
        else cmd_done <= 1'b1;
        @(posedge core_clk);
        cmd_start <= 1'b0;
        cmd_done <= 1'b0;
    endtask

    task automatic wait_sweep(output int t, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (age_sweep !== 1'b1 && n < lim);
        t = cyc;
        if (n >= lim) check(32'h0, 32'h1);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [2:0] d;
        logic [2:0] e;
        void'($urandom(20773));
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        t0 = cyc + 1;
        bus_read(IDX_CMD_STS, 32'h0000_0000);
        check(drop_all, 1'b1);
        check(age_enable, 1'b1);
        check(allow_broadcast, 1'b0);
        lookup(INGRESS_PORT2, 3'h3, 3'h0);
        void'(res_q.pop_back());
        bus_read(IDX_CFG, 32'h0129_0002);
        bus_read(IDX_OVERRIDE, 32'h0000_0000);
        // software waits for init done before writing configuration
        while (drop_all !== 1'b0) @(posedge core_clk);
        t1 = cyc - t0;
        check(32'(t1 >= 396 && t1 <= 404), 32'h1);
        bus_read(IDX_CMD_STS, 32'h0000_0002);
        bus_write(IDX_CFG, 32'hFFFF_FFFF);
        bus_read(IDX_CFG, 32'h0FFF_0007);
        bus_write(IDX_CFG, 32'h0000_0000);
        bus_read(IDX_CFG, 32'h0000_0000);
        // only the byte lane 2 write lands: low byte of the aging field
        avs_byteenable <= 4'h4;
        bus_write(IDX_CFG, 32'hFFFF_FFFF);
        avs_byteenable <= 4'hF;
        bus_read(IDX_CFG, 32'h00FF_0000);
        bus_write(IDX_OVERRIDE, 32'hFFFF_FFFF);
        bus_read(IDX_OVERRIDE, 32'h0000_0700);
        bus_write(IDX_CMD_STS, 32'hFFFF_FFFF);
        bus_read(IDX_CMD_STS, 32'h0000_0002);
        bus_read(14'h0100, 32'h0000_0000);
        pulse_cmd(1'b1);
        bus_read(IDX_CMD_STS, 32'h0000_0003);
        pulse_cmd(1'b0);
        bus_read(IDX_CMD_STS, 32'h0000_0002);
        // interrupt: raise, mask, clear
        bus_read(IDX_IRQ_STATUS, 32'h0000_0003);
        check(irq, 1'b0);
        bus_write(IDX_IRQ_ENABLE, 32'h0000_0002);
        @(posedge core_clk);
        check(irq, 1'b1);
        bus_write(IDX_IRQ_CLEAR, 32'h0000_0002);
        @(posedge core_clk);
        check(irq, 1'b0);
        bus_read(IDX_IRQ_STATUS, 32'h0000_0001);
        // every selector code, enabled and disabled, port 2 and other ingress
        for (int k = 0; k < 8; k++) begin
            bus_write(IDX_OVERRIDE, {21'h0, 2'(k >> 1), 1'(k), 8'h00});
            repeat (3) begin
                d = 3'($urandom());
                e = d;
                if (k[0] && k[2:1] == 2'h0) e = DEST_PORT0;
                if (k[0] && k[2:1] == 2'h1) e = DEST_PORT1;
                lookup(INGRESS_PORT2, d, e);
                lookup(2'($urandom() % 2), d, d);
            end
        end
        // aging in test units: interval of (field + 1) milliseconds
        bus_write(IDX_CFG, 32'h0002_0003);
        @(posedge core_clk);
        check(age_enable, 1'b1);
        wait_sweep(t0, 200);
        wait_sweep(t1, 200);
        wait_sweep(t2, 200);
        check(t2 - t1, 3 * MSC);
        // seconds unit, interval of one second; first sweep may be a stale one
        bus_write(IDX_CFG, 32'h0000_0002);
        wait_sweep(t0, 4100);
        wait_sweep(t1, 4100);
        wait_sweep(t2, 4100);
        check(t2 - t1, MSC * MS_PER_S);
        bus_write(IDX_CFG, 32'h0002_0004);
        @(posedge core_clk);
        check(age_enable, 1'b0);
        check(allow_broadcast, 1'b1);
        repeat (60) begin
            @(posedge core_clk);
            check(age_sweep, 1'b0);
        end
        bus_read(IDX_IRQ_STATUS, 32'h0000_0005);
        bus_write(IDX_IRQ_ENABLE, 32'h0000_0004);
        @(posedge core_clk);
        check(irq, 1'b1);
        bus_write(IDX_IRQ_CLEAR, 32'h0000_0007);
        @(posedge core_clk);
        check(irq, 1'b0);
        repeat (5) @(posedge core_clk);
        check(rd_q.size() + res_q.size(), 32'h0);
        tally_and_finish();
    end
endmodule

// >>> verilog/slt_ctrl.sv
// lookup table control registers: init sequencing, aging timer, port-2 override
module slt_ctrl
    import slt_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DFLT
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [15:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic cmd_start,
    input wire logic cmd_done,
    input wire logic lookup_valid,
    input wire logic [1:0] lookup_ingress,
    input wire logic [2:0] lookup_dest,
    output logic result_valid,
    output logic [2:0] result_dest,
    output logic drop_all,
    output logic age_enable,
    output logic age_sweep,
    output logic allow_broadcast,
    output logic irq
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_INIT = 2'b01,
        ST_RUN = 2'b10
    } slt_phase_t;

    typedef struct packed {
        slt_phase_t phase;
        logic [8:0] init_cnt;
        logic init_done;
        logic pending;
        logic [11:0] aging_time;
        logic age_en;
        logic bcast;
        logic test;
        logic ovr_en;
        logic [1:0] ovr_sel;
        logic [MS_CNT_W-1:0] ms_cnt;
        logic [9:0] ms_in_s;
        logic ms_tick;
        logic sec_tick;
        logic [11:0] age_cnt;
        logic age_sweep;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_enable;
        logic ack;
        logic [31:0] readdata;
        logic result_valid;
        logic [2:0] result_dest;
    } slt_state_t;

    localparam slt_state_t ST_RESET = '{
        phase: ST_INIT,
        init_cnt: 9'h000,
        init_done: 1'b0,
        pending: 1'b0,
        aging_time: AGE_TIME_RST, //RL6
        age_en: AGE_EN_RST,
        bcast: BCAST_RST,
        test: TEST_RST,
        ovr_en: OVR_EN_RST,
        ovr_sel: OVR_SEL_RST,
        ms_cnt: '0,
        ms_in_s: 10'h000,
        ms_tick: 1'b0,
        sec_tick: 1'b0,
        age_cnt: 12'h000,
        age_sweep: 1'b0,
        irq_status: '0,
        irq_enable: '0,
        ack: 1'b0,
        readdata: 32'h0000_0000,
        result_valid: 1'b0,
        result_dest: 3'h0
    };

    localparam logic [MS_CNT_W-1:0] MS_CNT_LAST = MS_CNT_W'(MS_CYCLES - 1);

    slt_state_t st;
    slt_state_t next_st;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] be_mask(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    function automatic logic [31:0] read_word(input slt_state_t s, input logic [13:0] idx);
        logic [31:0] w;
        w = 32'h0000_0000;
        // unlisted bits stay zero, so reserved fields read as zero
        unique case (idx)
            IDX_CMD_STS: begin
                w[STS_PENDING_BIT] = s.pending;
                w[STS_INIT_DONE_BIT] = s.init_done;
            end
            IDX_CFG: begin
                w[CFG_AGE_MSB:CFG_AGE_LSB] = s.aging_time;
                w[CFG_BCAST_BIT] = s.bcast;
                w[CFG_AGE_EN_BIT] = s.age_en;
                w[CFG_TEST_BIT] = s.test;
            end
            IDX_OVERRIDE: begin
                w[OVR_SEL_MSB:OVR_SEL_LSB] = s.ovr_sel;
                w[OVR_EN_BIT] = s.ovr_en;
            end
            IDX_IRQ_STATUS: w[IRQ_W-1:0] = s.irq_status;
            IDX_IRQ_ENABLE: w[IRQ_W-1:0] = s.irq_enable;
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [13:0] idx;
        logic [31:0] mask;
        logic [31:0] wd;
        logic wr_now;
        logic unit_tick;
        logic [IRQ_W-1:0] events;
        logic [IRQ_W-1:0] clr;
        idx = avs_address[15:2];
        mask = be_mask(avs_byteenable);
        wd = avs_writedata & mask;
        wr_now = avs_write && st.ack;
        unit_tick = 1'b0;
        events = '0;
        clr = '0;
        next_st = st;
        next_st.ms_tick = 1'b0;
        next_st.sec_tick = 1'b0;
        next_st.age_sweep = 1'b0;
        next_st.result_valid = 1'b0;

        // table initialization after reset; done bit sets itself
        unique case (st.phase)
            ST_INIT: begin
                if (st.init_cnt == INIT_CNT_LAST) begin //RL1
                    next_st.phase = ST_RUN;
                    next_st.init_done = 1'b1; //RL1
                end else begin
                    next_st.init_cnt = st.init_cnt + 9'h001;
                end
            end
            ST_RUN: begin
                next_st.init_done = 1'b1;
            end
        endcase

        // millisecond and second prescalers run free
        if (st.ms_cnt == MS_CNT_LAST) begin
            next_st.ms_cnt = '0;
            next_st.ms_tick = 1'b1;
        end else begin
            next_st.ms_cnt = st.ms_cnt + MS_CNT_W'(1);
        end
        if (st.ms_tick) begin
            if (st.ms_in_s == MS_PER_S_LAST) begin
                next_st.ms_in_s = 10'h000;
                next_st.sec_tick = 1'b1;
            end else begin
                next_st.ms_in_s = st.ms_in_s + 10'h001;
            end
        end

        // aging interval of (field + 1) units; unit is ms in test mode
        unit_tick = st.test ? st.ms_tick : st.sec_tick; //RL9
        if (!st.age_en) begin //RL8
            next_st.age_cnt = 12'h000;
        end else if (unit_tick) begin
            if (st.age_cnt >= st.aging_time) begin //RL5
                next_st.age_cnt = 12'h000;
                next_st.age_sweep = 1'b1;
            end else begin
                next_st.age_cnt = st.age_cnt + 12'h001;
            end
        end

        // command pending: start wins over a same-cycle completion
        if (cmd_start) begin //RL4
            next_st.pending = 1'b1;
        end else if (cmd_done) begin //RL4
            next_st.pending = 1'b0;
        end

        // bus: one wait cycle latches read data, access completes next
        next_st.ack = (avs_read || avs_write) && !st.ack;
        if (avs_read && !st.ack) begin
            next_st.readdata = read_word(st, idx);
        end
        if (wr_now) begin
            unique case (idx)
                IDX_CFG: begin
                    // only defined fields are stored, reserved bits ignore writes
                    if (avs_byteenable[2] || avs_byteenable[3]) begin
                        next_st.aging_time = (st.aging_time & ~mask[CFG_AGE_MSB:CFG_AGE_LSB])
                            | wd[CFG_AGE_MSB:CFG_AGE_LSB]; //RL12
                    end
                    if (avs_byteenable[0]) begin
                        next_st.bcast = avs_writedata[CFG_BCAST_BIT]; //RL7
                        next_st.age_en = avs_writedata[CFG_AGE_EN_BIT]; //RL8
                        next_st.test = avs_writedata[CFG_TEST_BIT]; //RL9
                    end
                end
                IDX_OVERRIDE: begin
                    if (avs_byteenable[1]) begin
                        next_st.ovr_en = avs_writedata[OVR_EN_BIT]; //RL11
                        next_st.ovr_sel = avs_writedata[OVR_SEL_MSB:OVR_SEL_LSB]; //RL10
                    end
                end
                IDX_IRQ_CLEAR: begin
                    if (avs_byteenable[0]) begin
                        clr = avs_writedata[IRQ_W-1:0];
                    end
                end
                IDX_IRQ_ENABLE: begin
                    if (avs_byteenable[0]) begin
                        next_st.irq_enable = avs_writedata[IRQ_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // sticky events; a set in the clear cycle survives
        events[EV_INIT_DONE] = next_st.init_done && !st.init_done;
        events[EV_CMD_DONE] = st.pending && cmd_done && !cmd_start;
        events[EV_AGE_SWEEP] = next_st.age_sweep;
        next_st.irq_status = (st.irq_status & ~clr) | events;

        // lookup result, dropped during init, port-2 override applied
        if (lookup_valid && st.init_done) begin //RL2
            next_st.result_valid = 1'b1;
            next_st.result_dest = lookup_dest;
            if (lookup_ingress == INGRESS_PORT2 && st.ovr_en) begin //RL11
                // reserved selector codes leave the lookup result alone
                if (st.ovr_sel == OVR_SEL_PORT0) begin //RL10
                    next_st.result_dest = DEST_PORT0;
                end else if (st.ovr_sel == OVR_SEL_PORT1) begin //RL10
                    next_st.result_dest = DEST_PORT1;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign avs_readdata = st.readdata;
    assign avs_waitrequest = (avs_read || avs_write) && !st.ack;
    assign result_valid = st.result_valid;
    assign result_dest = st.result_dest;
    assign drop_all = !st.init_done; //RL2
    assign age_enable = st.age_en;
    assign age_sweep = st.age_sweep;
    assign allow_broadcast = st.bcast; //RL7
    assign irq = |(st.irq_status & st.irq_enable);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    sequence port2_override_s(logic [1:0] sel);
        lookup_valid && st.init_done && lookup_ingress == INGRESS_PORT2
            && st.ovr_en && st.ovr_sel == sel;
    endsequence

    sequence cfg_read_s;
        avs_read && !st.ack && avs_address[15:2] == IDX_CFG;
    endsequence

    init_done_time_a: assert property ($rose(st.init_done) |-> //RL1
        $past(st.init_cnt) == INIT_CNT_LAST && $past(st.phase) == ST_INIT)
        else $error("init done set at wrong count");

    init_done_hold_a: assert property (st.init_done |=> st.init_done) //RL1
        else $error("init done fell without reset");

    drop_during_init_a: assert property ($rose(resetn) |-> //RL2
        (drop_all && !result_valid) [*8])
        else $error("packets not dropped during init");

    pend_set_a: assert property (cmd_start |=> st.pending) //RL4
        else $error("pending not set by command start");

    pend_clear_a: assert property (cmd_done && !cmd_start |=> !st.pending) //RL4
        else $error("pending not cleared at completion");

    age_interval_a: assert property (age_sweep |-> //RL5
        $past(st.age_cnt) >= $past(st.aging_time) && $past(st.age_en))
        else $error("aging sweep before interval end");

    age_unit_a: assert property (age_sweep && !$past(st.test) |-> $past(st.sec_tick)) //RL9
        else $error("aging counted in wrong unit");

    cfg_reset_a: assert property ($rose(resetn) |-> //RL6
        st.aging_time == AGE_TIME_RST && st.age_en && !st.bcast && !st.test)
        else $error("configuration reset values wrong");

    age_disabled_a: assert property (!st.age_en |=> !age_sweep) //RL8
        else $error("aging ran while disabled");

    override_port0_a: assert property (port2_override_s(OVR_SEL_PORT0) |=> //RL10
        result_valid && result_dest == DEST_PORT0)
        else $error("port-2 override to port 0 not applied");

    override_port1_a: assert property (port2_override_s(OVR_SEL_PORT1) |=> //RL11
        result_valid && result_dest == DEST_PORT1)
        else $error("port-2 override to port 1 not applied");

    reserved_zero_a: assert property (cfg_read_s ##1 avs_read |-> //RL12
        !avs_waitrequest && avs_readdata[31:28] == 4'h0 && avs_readdata[15:3] == 13'h0000)
        else $error("reserved configuration bits not zero");

endmodule
